// [bbrc_config.sv]
// Rate select and interrupt pin drive registers of the radio baseband
// Assumes the serial port logic presents decoded byte accesses on clk
//
// Notes on behaviour
// RL1: Rate bit 2: 1=32 chips, 0=64.
// RL2: Rate bit 1 selects double rate.
// RL3: Data-rate bit honoured only with 32-chip codes.
// RL4: Double rate splits 64-chip code into halves.
// RL5: Double rate transmits even bit counts only.
// RL6: Normal 32-chip rate may use two codes.
// RL7: Rate bit 0: 1=12x, 0=6x oversampling.
// RL8: Oversampling bit ignored for 64-chip or double.
// RL9: Host never writes patterns 001,010,011,111.
// RL10: Host writes zero to reserved upper bits.
// RL11: Pin bits 1:0 choose interrupt pin drive.
// RL12: Half select picks upper/lower 32 code bits.
// RL13: Pin stage is value plus output enable.
`timescale 1ns/1ps
`include "bbrc_defs.svh"

module bbrc_config (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire bbrc_pkg::bbrc_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Baseband side
    input wire logic codeHalfSelect,
    input wire logic irqRequest,
    output bbrc_pkg::bbrc_mode_t mode,
    // Interrupt pin
    output logic irqPinOut,
    output logic irqPinOe
);
    import bbrc_pkg::*;

    // A write is stored at the edge that takes it and shows on the mode
    // and pin outputs one edge later; a read answers at the same edge it is
    // taken, and a read beside a write returns the value before the write

    ////////////////////////////////////////////////////////////////////
    // Field layout of the two registers
    // Only the low bits are stored; reserved bits cost no flops
    localparam int RateBits = 3;
    localparam int PinBits = 2;
    localparam int ModeBits = 6;
    localparam int WidthPos = `BBRC_BIT_WIDTH;
    localparam int DdrPos = `BBRC_BIT_DDR;
    localparam int SampPos = `BBRC_BIT_SAMP;
    localparam int ClkMhz = `BBRC_SYS_CLK_MHZ;
    localparam logic [7:0] RateRstByte = `BBRC_RST_RATE;
    localparam logic [7:0] PinRstByte = `BBRC_RST_PIN;
    localparam logic [7:0] AddrRate = `BBRC_ADDR_RATE;
    localparam logic [7:0] AddrPin = `BBRC_ADDR_PIN;
    localparam logic [RateBits-1:0] RateRst = RateRstByte[RateBits-1:0];
    localparam logic [PinBits-1:0] PinRst = PinRstByte[PinBits-1:0];

    ////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // Refuse a layout that the decode below cannot serve
    if (RateBits > 8 || PinBits > 8) begin : gStoreWidth
        $error("Stored fields wider than a register");
    end
    if ($bits(bbrc_pin_mode_t) != PinBits) begin : gPinType
        $error("Pin mode type does not match the stored pin field");
    end
    if ($bits(bbrc_mode_t) != ModeBits) begin : gModeType
        $error("Mode bundle does not hold six flags");
    end
    if (WidthPos >= RateBits) begin : gWidthPos
        $error("Code width position outside the stored bits");
    end
    if (DdrPos >= RateBits) begin : gDdrPos
        $error("Data rate position outside the stored bits");
    end
    if (SampPos >= RateBits) begin : gSampPos
        $error("Sample rate position outside the stored bits");
    end
    if (WidthPos == DdrPos) begin : gOverlapWd
        $error("Code width and data rate fields overlap");
    end
    if (WidthPos == SampPos) begin : gOverlapWs
        $error("Code width and sample rate fields overlap");
    end
    if (DdrPos == SampPos) begin : gOverlapDs
        $error("Data rate and sample rate fields overlap");
    end
    if (RateRstByte[7:RateBits] != '0) begin : gRateRst
        $error("Rate reset value sets reserved bits");
    end
    if (RateRst inside {3'h1, 3'h2, 3'h3, 3'h7}) begin : gRateRstPat
        $error("Rate reset value is a refused pattern");
    end
    if (PinRstByte[7:PinBits] != '0) begin : gPinRst
        $error("Pin reset value sets reserved bits");
    end
    // The pin field is cast straight to the mode type
    if (BBRC_PIN_CMOS_INV != 2'h0) begin : gCodeInv
        $error("Inverted push-pull code differs from the field");
    end
    if (BBRC_PIN_CMOS != 2'h1) begin : gCodeCmos
        $error("Push-pull code differs from the field");
    end
    if (BBRC_PIN_OPEN_DRAIN != 2'h2) begin : gCodeDrain
        $error("Open drain code differs from the field");
    end
    if (BBRC_PIN_OPEN_SOURCE != 2'h3) begin : gCodeSource
        $error("Open source code differs from the field");
    end
    if (AddrRate == AddrPin) begin : gAddr
        $error("Rate and pin registers share an offset");
    end
    if (ClkMhz <= 0) begin : gClk
        $error("System clock rate must be positive");
    end

    ////////////////////////////////////////////////////////////////////
    // Address decode
    // Accesses to any other offset touch nothing and read as zero
    logic hitRate, hitPin, wrRate, wrPin, rdRate, rdPin;

    always_comb begin
        hitRate = (req.addr == AddrRate);
        hitPin = (req.addr == AddrPin);
        wrRate = req.wr & hitRate;
        wrPin = req.wr & hitPin;
        rdRate = req.rd & hitRate;
        rdPin = req.rd & hitPin;
    end

    ////////////////////////////////////////////////////////////////////
    // Register file
    // Refused rate patterns are stored as written and only flagged
    logic [RateBits-1:0] rate_r, rate_nxt;
    bbrc_pin_mode_t pin_r, pin_nxt;

    always_comb begin
        rate_nxt = rate_r;
        pin_nxt = pin_r;
        // Reserved bits are dropped; host keeps them zero [RL10]
        if (wrRate) begin
            rate_nxt = req.wdata[RateBits-1:0];
        end
        if (wrPin) begin
            pin_nxt = bbrc_pin_mode_t'(req.wdata[PinBits-1:0]);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_r <= RateRst;
            pin_r <= bbrc_pin_mode_t'(PinRst);
        end else begin
            rate_r <= rate_nxt;
            pin_r <= pin_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path
    // Read data holds until the next read; valid is a one-cycle pulse
    logic [7:0] rateByte, pinByte;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;

    always_comb begin
        rateByte = 8'h00;
        rateByte[RateBits-1:0] = rate_r;
        pinByte = 8'h00;
        pinByte[PinBits-1:0] = pin_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        if (req.rd) begin
            rvalid_nxt = 1'b1;
            if (rdRate) begin
                rdata_nxt = rateByte;
            end else if (rdPin) begin
                rdata_nxt = pinByte;
            end else begin
                // Unmapped offsets read as zero
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign rdata = rdata_r;
    assign rvalid = rvalid_r;

    ////////////////////////////////////////////////////////////////////
    // Effective baseband mode
    // Levels the baseband may read in any cycle; raw bits never leave
    // this block, so ignored bits cannot leak into the datapath
    bbrc_mode_t mode_r, mode_nxt;
    logic wShort, wDdr, wSamp, normalShort, ddrActive, rateBad;

    always_comb begin
        wShort = rate_r[WidthPos];
        wDdr = rate_r[DdrPos];
        wSamp = rate_r[SampPos];
        // 64-chip codes ignore both lower bits
        normalShort = wShort & ~wDdr;
        ddrActive = wShort & wDdr; // [RL3]
        // Patterns the host must avoid, kept visible to the baseband [RL9]
        case (rate_r)
            3'h0: rateBad = 1'b0;
            3'h1: rateBad = 1'b1;
            3'h2: rateBad = 1'b1;
            3'h3: rateBad = 1'b1;
            3'h4: rateBad = 1'b0;
            3'h5: rateBad = 1'b0;
            3'h6: rateBad = 1'b0;
            3'h7: rateBad = 1'b1;
            default: rateBad = 1'b1;
        endcase
        mode_nxt.codeShort = wShort; // [RL1]
        mode_nxt.doubleRate = ddrActive; // [RL2] [RL3]
        mode_nxt.oversample12 = normalShort & wSamp; // [RL7] [RL8]
        // Half select only in normal 32-chip; double rate uses both halves
        mode_nxt.codeHalfUpper = normalShort & codeHalfSelect; // [RL12] [RL4] [RL6]
        mode_nxt.evenBitsOnly = ddrActive; // [RL5]
        mode_nxt.rateInvalid = rateBad;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= '0;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    assign mode = mode_r;

    ////////////////////////////////////////////////////////////////////
    // Interrupt pin drive
    // Each mode gives the level while asserted, the level while idle,
    // and whether idle releases the pin to the board's pull
    // Idle level of the two released modes matters only while enabled
    logic pinOut_r, pinOut_nxt, pinOe_r, pinOe_nxt;
    logic assertLevel, idleLevel, idleFloats;

    always_comb begin
        case (pin_r) // [RL11]
            BBRC_PIN_OPEN_SOURCE: begin
                assertLevel = 1'b1;
                idleLevel = 1'b1;
                idleFloats = 1'b1;
            end
            BBRC_PIN_OPEN_DRAIN: begin
                assertLevel = 1'b0;
                idleLevel = 1'b0;
                idleFloats = 1'b1;
            end
            BBRC_PIN_CMOS: begin
                assertLevel = 1'b1;
                idleLevel = 1'b0;
                idleFloats = 1'b0;
            end
            BBRC_PIN_CMOS_INV: begin
                assertLevel = 1'b0;
                idleLevel = 1'b1;
                idleFloats = 1'b0;
            end
            default: begin
                assertLevel = 1'b0;
                idleLevel = 1'b1;
                idleFloats = 1'b0;
            end
        endcase
        // Floating idle is a released enable, not a driven level [RL13]
        if (irqRequest) begin
            pinOut_nxt = assertLevel;
            pinOe_nxt = 1'b1;
        end else begin
            pinOut_nxt = idleLevel;
            pinOe_nxt = ~idleFloats;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOut_r <= 1'b0;
            pinOe_r <= 1'b1;
        end else begin
            pinOut_r <= pinOut_nxt;
            pinOe_r <= pinOe_nxt;
        end
    end

    assign irqPinOut = pinOut_r;
    assign irqPinOe = pinOe_r;
endmodule

// [bbrc_defs.svh]
// Register offsets, field positions, reset values and the system clock rate
// Assumes inclusion by bare name from the top module only
`ifndef BBRC_DEFS_SVH
`define BBRC_DEFS_SVH
`define BBRC_ADDR_RATE 8'h04
`define BBRC_ADDR_PIN 8'h05
`define BBRC_RST_RATE 8'h00
`define BBRC_RST_PIN 8'h01
`define BBRC_BIT_WIDTH 2
`define BBRC_BIT_DDR 1
`define BBRC_BIT_SAMP 0
`define BBRC_SYS_CLK_MHZ 125
`endif

// [bbrc_pkg.sv]
// Types for the rate and interrupt pin configuration bank
// Assumes bbrc_defs.svh is on the include path
package bbrc_pkg;
    typedef enum logic [1:0] {
        BBRC_PIN_CMOS_INV = 2'h0,
        BBRC_PIN_CMOS = 2'h1,
        BBRC_PIN_OPEN_DRAIN = 2'h2,
        BBRC_PIN_OPEN_SOURCE = 2'h3
    } bbrc_pin_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bbrc_req_t;

    typedef struct packed {
        logic codeShort;
        logic doubleRate;
        logic oversample12;
        logic codeHalfUpper;
        logic evenBitsOnly;
        logic rateInvalid;
    } bbrc_mode_t;
endpackage

// [bbrc_host.sv]
// Host model driving the register port of the rate and pin bank
// Assumes the bank takes req on rising clk
`timescale 1ns/1ps
module bbrc_host (
    input wire logic clk,
    output bbrc_pkg::bbrc_req_t req
);
    import bbrc_pkg::*;
    initial req = '0;
    // One access: held over the taking edge, then released
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        req <= '{a, d, w, !w};
        @(posedge clk);
        req <= '0;
    endtask
endmodule

// [bbrc_chk.sv]
// Checker for the rate and pin bank
// Assumes binding to bbrc_config
`timescale 1ns/1ps
module bbrc_chk (
    input wire logic clk,
    input wire logic rst,
    input wire bbrc_pkg::bbrc_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire bbrc_pkg::bbrc_mode_t mode,
    input wire logic irqRequest,
    input wire logic irqPinOe
);
    wire w4 = req.wr && req.addr == 8'h04;
    wire [7:0] d = req.wdata;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    code_width_a: assert property (w4 |=> ##1 mode.codeShort == $past(d[2], 2))
        else $error("code width");
    double_rate_a: assert property (w4 |=> ##1 mode.doubleRate == $past(d[2] & d[1], 2))
        else $error("double rate");
    sample_rate_a: assert property (w4 |=> ##1 mode.oversample12 == $past(d[2] & ~d[1] & d[0], 2))
        else $error("sample rate");
    even_bits_a: assert property (mode.evenBitsOnly == mode.doubleRate)
        else $error("even bits");
    half_select_a: assert property (mode.codeHalfUpper |-> mode.codeShort && !mode.doubleRate)
        else $error("half select");
    pin_float_a: assert property (!irqPinOe |-> !$past(irqRequest))
        else $error("pin float");
    reserved_zero_a: assert property (rvalid |-> rdata[7:3] == 5'h00)
        else $error("reserved bits");
    pin_read_a: assert property (req.rd && req.addr == 8'h05 |=> rvalid && rdata[7:2] == 6'h00)
        else $error("pin read");
endmodule
bind bbrc_config bbrc_chk i_bbrc_chk (.clk, .rst, .req, .rdata, .rvalid, .mode, .irqRequest, .irqPinOe);

// [testbench.sv]
// Self-checking testbench for the rate and pin bank
// Assumes the host model and checker are compiled alongside
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("Error %0t mismatch", $time); end end
module testbench;
    import bbrc_pkg::*;
    logic clk = 0, rst = 1, codeHalfSelect = 0, irqRequest = 0, rvalid, irqPinOut, irqPinOe;
    logic [7:0] rdata;
    bbrc_req_t req;
    bbrc_mode_t mode;
    int errors = 0, samples_checked = 0;
    always #4 clk = ~clk;
    bbrc_config i_bbrc_config (.clk, .rst, .req, .rdata, .rvalid, .codeHalfSelect, .irqRequest,
        .mode, .irqPinOut, .irqPinOe);
    bbrc_host i_bbrc_host (.clk, .req);
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_bbrc_host.acc(0, a, 8'h00);
        #1 `CHK({rvalid, rdata}, {1'b1, e})
        @(posedge clk);
    endtask
    task automatic print_verdict;
        $display("errors=%0d checks=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        static logic [2:0] v [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
        logic [2:0] r;
        logic [1:0] p;
        repeat (16) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h01);
        rd(8'h06, 8'h00);
        foreach (v[i]) begin
            r = v[i];
            codeHalfSelect <= i[0];
            i_bbrc_host.acc(1, 8'h04, {5'h00, r});
            repeat (2) @(posedge clk);
            #1 `CHK(mode, {r[2], r[2] & r[1], r[2] & ~r[1] & r[0], r[2] & ~r[1] & i[0], r[2] & r[1], 1'b0})
            @(posedge clk);
            rd(8'h04, {5'h00, r});
        end
        for (int m = 0; m < 8; m++) begin
            p = m[2:1];
            i_bbrc_host.acc(1, 8'h05, {6'h00, p});
            irqRequest <= m[0];
            repeat (2) @(posedge clk);
            #1 `CHK({irqPinOut, irqPinOe}, p[1] ? {p[0], m[0]} : {~(p[0] ^ m[0]), 1'b1})
            @(posedge clk);
        end
        print_verdict();
    end
    initial begin
        #20000;
        errors++;
        print_verdict();
    end
endmodule
